// ---- fll_defines.svh ----
`ifndef FLL_DEFINES_SVH
`define FLL_DEFINES_SVH

// ============================================================
// Register indexes (byte address is four times the index)
`define IDX_MODE_ENABLE 8'h74
`define IDX_DIVIDER 8'h75
`define IDX_FRACTION 8'h76
`define IDX_INTEGER_GAIN 8'h77
`define IDX_STATUS 8'h80

// ============================================================
// Field positions
`define FRACTION_SELECT_BIT 2
`define OSC_ENABLE_BIT 1
`define LOOP_ENABLE_BIT 0
`define OUTDIV_HI 13
`define OUTDIV_LO 8
`define CTRL_RATE_HI 6
`define CTRL_RATE_LO 4
`define RATIO_HI 2
`define RATIO_LO 0
`define INT_MULT_HI 14
`define INT_MULT_LO 5
`define GAIN_HI 3
`define GAIN_LO 0

// ============================================================
// Writable bit masks
`define MASK_MODE_ENABLE 16'h0007
`define MASK_DIVIDER 16'h3F77
`define MASK_FRACTION 16'hFFFF
`define MASK_INTEGER_GAIN 16'h7FEF

// ============================================================
// Reset values
`define RST_MODE_ENABLE 16'h0000
`define RST_DIVIDER 16'h0007
`define RST_FRACTION 16'h0000
`define RST_INTEGER_GAIN 16'h2EE0

// ============================================================
// Limits
`define OUTDIV_MIN_CODE 6'h03
`define GAIN_MAX_CODE 4'h8

`endif

// ---- fll_pkg.sv ----
package fll_pkg;

  // ============================================================
  // Configuration handed to the analogue loop
  typedef struct packed {
    logic fractionSelect;
    logic oscEnable;
    logic loopEnable;
    logic [4:0] ratioDivide;
    logic [9:0] intMultiplier;
    logic [15:0] fracMultiplier;
    logic [3:0] gainShift;
  } loop_cfg_s;

  // ============================================================
  // State of the rate divider
  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
    logic level;
  } div_state_s;

  // ============================================================
  // State of the configuration block
  typedef struct packed {
    logic [15:0] modeEnable;
    logic [15:0] divider;
    logic [15:0] fraction;
    logic [15:0] intGain;
    logic ack;
    logic [31:0] rdata;
    logic [4:0] ratio;
    logic [3:0] shift;
    logic signed [23:0] scaled;
  } cfg_state_s;

endpackage

// ---- rate_divider.sv ----
`timescale 1ns/1ps

module rate_divider (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [5:0] limit,
  output logic tick,
  output logic level
);

  fll_pkg::div_state_s st_r;
  fll_pkg::div_state_s st_nxt;

  // ============================================================
  // Counts limit+1 cycles per tick; level high for the first half
  always_comb begin
    st_nxt = st_r;
    if (!en) begin
      st_nxt.cnt = 6'h00;
      st_nxt.tick = 1'b0;
      st_nxt.level = 1'b0;
    end else begin
      // A lowered limit restarts the count instead of wrapping past 63
      st_nxt.tick = (st_r.cnt >= limit);
      st_nxt.cnt = (st_r.cnt >= limit) ? 6'h00 : st_r.cnt + 6'h01;
      st_nxt.level = (st_r.cnt < limit[5:1] + 6'h01);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
  assign level = st_r.level;

  // ============================================================
  // Checks
  property p_idle_no_tick;
    @(posedge clock) disable iff (!rst_n) !en |=> !tick;
  endproperty
  a_idle_no_tick: assert property (p_idle_no_tick) // R12
    else $error("divider ticked while disabled");

  property p_div4_period;
    @(posedge clock) disable iff (!rst_n || !en)
      (tick && limit == 6'h03) ##1 (limit == 6'h03) [*3] |=>
        (tick && !$past(tick) && !$past(tick, 2) && !$past(tick, 3));
  endproperty
  a_div4_period: assert property (p_div4_period) // R4
    else $error("divide-by-4 period wrong");

endmodule // rate_divider

// ---- freq_locked_loop_config.sv ----
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`include "fll_defines.svh"

// Function
// (R1) Fraction-select bit 2 picks integer (0) or fractional (1) loop mode.
// (R2) Oscillator-enable bit 1 turns the free-running loop oscillator on.
// (R3) Software sets oscillator enable before loop enable; bit 0 runs loop.
// (R4) Output clock is oscillator divided by output-divider code plus one.
// (R5) Control block runs at oscillator rate over rate field plus one.
// (R6) Ratio field 2:0 resets 111 and divides by 1, 2, 4, 8, 16.
// (R7) Software uses ratio code 100 for references below 64kHz.
// (R8) Bits 15:0 are the fractional multiplier, top bit weighs one half.
// (R9) Bits 14:5 are the integer multiplier, reset 01_0111_0111.
// (R10) Loop error is scaled by two to the gain code, up to 256.
// (R11) Software keeps the predivided reference at or below 13.5MHz.
// (R12) Reserved divider codes and a clear loop enable hold output still.
module freq_locked_loop_config (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic signed [15:0] loopError,
  output logic signed [23:0] scaledError,
  output fll_pkg::loop_cfg_s loopCfg,
  output logic outClockTick,
  output logic outClockLevel,
  output logic ctrlBlockTick
);

  localparam fll_pkg::cfg_state_s RESET_STATE = '{
    modeEnable: `RST_MODE_ENABLE,
    divider: `RST_DIVIDER,
    fraction: `RST_FRACTION,
    intGain: `RST_INTEGER_GAIN,
    ack: 1'b0,
    rdata: 32'h00000000,
    ratio: 5'h10,
    shift: 4'h0,
    scaled: 24'sh000000
  };

  fll_pkg::cfg_state_s st_r;
  fll_pkg::cfg_state_s st_nxt;

  logic [5:0] outDivCode;
  logic [2:0] ctrlRateCode;
  logic [2:0] ratioCode;
  logic [3:0] gainCode;
  logic outDivValid;
  logic outDivEn;
  logic ctrlEn;
  logic request;
  logic [15:0] statusWord;

  assign outDivCode = st_r.divider[`OUTDIV_HI:`OUTDIV_LO];
  assign ctrlRateCode = st_r.divider[`CTRL_RATE_HI:`CTRL_RATE_LO];
  assign ratioCode = st_r.divider[`RATIO_HI:`RATIO_LO];
  assign gainCode = st_r.intGain[`GAIN_HI:`GAIN_LO];
  assign outDivValid = (outDivCode >= `OUTDIV_MIN_CODE);
  assign request = cyc_i && stb_i && !st_r.ack;

  // ============================================================
  // Register merge under byte enables
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] sel,
                                        input logic [15:0] mask);
    logic [15:0] m;
    m = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    return m & mask;
  endfunction

  // ============================================================
  // Bus slave and derived settings
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = request;
    st_nxt.rdata = 32'h00000000;
    if (request) begin
      unique case (adr_i)
        {22'h000000, `IDX_MODE_ENABLE, 2'b00}: begin
          st_nxt.rdata = {16'h0000, st_r.modeEnable};
          if (we_i) begin
            st_nxt.modeEnable = merge(st_r.modeEnable, dat_i, sel_i,
                                      `MASK_MODE_ENABLE);
          end
        end
        {22'h000000, `IDX_DIVIDER, 2'b00}: begin
          st_nxt.rdata = {16'h0000, st_r.divider};
          if (we_i) begin
            st_nxt.divider = merge(st_r.divider, dat_i, sel_i,
                                   `MASK_DIVIDER);
          end
        end
        {22'h000000, `IDX_FRACTION, 2'b00}: begin
          st_nxt.rdata = {16'h0000, st_r.fraction};
          if (we_i) begin
            st_nxt.fraction = merge(st_r.fraction, dat_i, sel_i,
                                    `MASK_FRACTION);
          end
        end
        {22'h000000, `IDX_INTEGER_GAIN, 2'b00}: begin
          st_nxt.rdata = {16'h0000, st_r.intGain};
          if (we_i) begin
            st_nxt.intGain = merge(st_r.intGain, dat_i, sel_i,
                                   `MASK_INTEGER_GAIN);
          end
        end
        {22'h000000, `IDX_STATUS, 2'b00}: begin
          st_nxt.rdata = {16'h0000, statusWord};
        end
        default: begin
          st_nxt.rdata = 32'h00000000;
        end
      endcase
    end
    // Ratio divide: 000..011 power of two, any 1XX gives 16
    if (ratioCode[2]) begin // R6
      st_nxt.ratio = 5'h10;
    end else begin
      st_nxt.ratio = 5'(5'h01 << ratioCode[1:0]); // R6
    end
    // Codes above 1000 are unsupported; clamp at x256
    st_nxt.shift = (gainCode > `GAIN_MAX_CODE) ? `GAIN_MAX_CODE
                                               : gainCode; // R10
    st_nxt.scaled = 24'(24'(loopError) <<< st_r.shift); // R10
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= RESET_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ============================================================
  // Status view: loop active, reserved divider code, output level
  assign statusWord = {13'h0000, outClockLevel, !outDivValid,
                       st_r.modeEnable[`LOOP_ENABLE_BIT]};

  // ============================================================
  // Configuration outputs
  always_comb begin
    loopCfg.fractionSelect = st_r.modeEnable[`FRACTION_SELECT_BIT]; // R1
    loopCfg.oscEnable = st_r.modeEnable[`OSC_ENABLE_BIT]; // R2
    loopCfg.loopEnable = st_r.modeEnable[`LOOP_ENABLE_BIT]; // R3
    loopCfg.ratioDivide = st_r.ratio;
    loopCfg.intMultiplier = st_r.intGain[`INT_MULT_HI:`INT_MULT_LO]; // R9
    // Integer mode ignores the fractional part
    loopCfg.fracMultiplier = loopCfg.fractionSelect
                             ? st_r.fraction : 16'h0000; // R1 R8
    loopCfg.gainShift = st_r.shift;
  end

  assign dat_o = st_r.rdata;
  assign ack_o = st_r.ack;
  assign scaledError = st_r.scaled;

  // ============================================================
  // Output and control-block dividers
  assign outDivEn = st_r.modeEnable[`LOOP_ENABLE_BIT] && outDivValid; // R12
  assign ctrlEn = st_r.modeEnable[`LOOP_ENABLE_BIT];

  rate_divider outDiv (
    .clock(clock),
    .rst_n(rst_n),
    .en(outDivEn),
    .limit(outDivCode), // R4
    .tick(outClockTick),
    .level(outClockLevel)
  );

  rate_divider ctrlDiv (
    .clock(clock),
    .rst_n(rst_n),
    .en(ctrlEn),
    .limit({3'b000, ctrlRateCode}), // R5
    .tick(ctrlBlockTick),
    .level()
  );

  // ============================================================
  // Checks
  property p_ack_next;
    @(posedge clock) disable iff (!rst_n)
      (cyc_i && stb_i && !ack_o) |=> ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("no ack one cycle after request");

  property p_ack_single;
    @(posedge clock) disable iff (!rst_n) ack_o |=> !ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("ack held longer than one cycle");

  property p_enable_write;
    @(posedge clock) disable iff (!rst_n)
      (request && we_i && sel_i[0] &&
       adr_i == {22'h000000, `IDX_MODE_ENABLE, 2'b00})
      |=> (loopCfg.loopEnable == $past(dat_i[0]) &&
           loopCfg.oscEnable == $past(dat_i[1]) &&
           loopCfg.fractionSelect == $past(dat_i[2]));
  endproperty
  a_enable_write: assert property (p_enable_write) // R2
    else $error("mode write not applied");

  property p_integer_mode;
    @(posedge clock) disable iff (!rst_n)
      !loopCfg.fractionSelect |-> loopCfg.fracMultiplier == 16'h0000;
  endproperty
  a_integer_mode: assert property (p_integer_mode) // R1
    else $error("fraction used in integer mode");

  property p_loop_off_quiet;
    @(posedge clock) disable iff (!rst_n)
      !loopCfg.loopEnable |=> (!outClockTick && !ctrlBlockTick);
  endproperty
  a_loop_off_quiet: assert property (p_loop_off_quiet) // R12
    else $error("divider ran with loop disabled");

  property p_reserved_quiet;
    @(posedge clock) disable iff (!rst_n)
      (outDivCode < `OUTDIV_MIN_CODE) |=> !outClockTick;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) // R12
    else $error("output ticked on reserved code");

  property p_ratio_decode;
    @(posedge clock) disable iff (!rst_n)
      $stable(ratioCode) |=>
        loopCfg.ratioDivide == ($past(ratioCode[2]) ? 5'h10 :
                                5'(5'h01 << $past(ratioCode[1:0])));
  endproperty
  a_ratio_decode: assert property (p_ratio_decode) // R6
    else $error("ratio divide decode wrong");

  property p_ctrl_every_cycle;
    @(posedge clock) disable iff (!rst_n)
      (ctrlEn && ctrlRateCode == 3'h0) [*2] |=> ctrlBlockTick;
  endproperty
  a_ctrl_every_cycle: assert property (p_ctrl_every_cycle) // R5
    else $error("control block not at full rate");

  property p_reset_values;
    @(posedge clock) !rst_n |=>
      (ratioCode == 3'h7 && loopCfg.intMultiplier == 10'h177 &&
       !loopCfg.loopEnable);
  endproperty
  a_reset_values: assert property (p_reset_values) // R9
    else $error("reset values wrong");

  property p_gain_scale;
    @(posedge clock) disable iff (!rst_n)
      $stable(gainCode) && gainCode <= `GAIN_MAX_CODE |=>
        ##1 scaledError == 24'(24'($past(loopError)) <<< $past(gainCode, 2));
  endproperty
  a_gain_scale: assert property (p_gain_scale) // R10
    else $error("error gain scaling wrong");

  c_mode_write: cover property (@(posedge clock) disable iff (!rst_n)
    request && we_i && adr_i == {22'h000000, `IDX_MODE_ENABLE, 2'b00});
  c_out_tick: cover property (@(posedge clock) disable iff (!rst_n)
    outClockTick);
  c_reserved: cover property (@(posedge clock) disable iff (!rst_n)
    loopCfg.loopEnable && !outDivValid);
  c_gain_max: cover property (@(posedge clock) disable iff (!rst_n)
    st_r.shift == `GAIN_MAX_CODE);

endmodule // freq_locked_loop_config

// ---- testbench.sv ----
`timescale 1ns/1ps
`include "fll_defines.svh"

module testbench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cycI = 1'b0;
  logic stbI = 1'b0;
  logic weI = 1'b0;
  logic [31:0] adrI = 32'h0;
  logic [31:0] datI = 32'h0;
  logic [3:0] selI = 4'h0;
  logic [31:0] datO;
  logic ackO;
  logic signed [15:0] loopError = 16'sh0;
  logic signed [23:0] scaledError;
  logic signed [23:0] ex;
  fll_pkg::loop_cfg_s loopCfg;
  logic outClockTick, outClockLevel, ctrlBlockTick;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 32'hd9b15977;
  int per, hi, cnt;
  logic [31:0] expQ[$];
  logic [15:0] v;
  logic [9:0] n;
  logic [5:0] c;
  logic [5:0] codes[5] = '{6'h03, 6'h04, 6'h05, 6'h3F, 6'h00};

  always #50 clock = ~clock;

  freq_locked_loop_config u_dut (
    .clock(clock), .rst_n(rst_n), .cyc_i(cycI), .stb_i(stbI),
    .we_i(weI), .adr_i(adrI), .dat_i(datI), .sel_i(selI),
    .dat_o(datO), .ack_o(ackO), .loopError(loopError),
    .scaledError(scaledError), .loopCfg(loopCfg),
    .outClockTick(outClockTick), .outClockLevel(outClockLevel),
    .ctrlBlockTick(ctrlBlockTick)
  );

  // ============================================================
  // Reporting
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("Error timeout expected done seen hang");
      end_of_test();
    end
  end

  // Read results are matched against the oldest note
  always @(posedge clock) begin
    if (ackO === 1'b1 && weI === 1'b0) begin
      if (expQ.size() == 0) begin
        chk("unexpected read", 32'h0, 32'hFFFFFFFF);
      end else begin
        chk("read data", expQ.pop_front(), datO);
      end
    end
  end

  // ============================================================
  // Wishbone classic master
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [31:0] d, input logic [3:0] s);
    cycI <= 1'b1;
    stbI <= 1'b1;
    weI <= w;
    adrI <= {22'h0, idx, 2'b00};
    datI <= d;
    selI <= s;
    @(posedge clock);
    while (ackO !== 1'b1) @(posedge clock);
    cycI <= 1'b0;
    stbI <= 1'b0;
    weI <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, 4'h3);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, idx, 32'h0, 4'hF);
  endtask

  task automatic wdiv(input logic [5:0] od, input logic [2:0] rt,
                      input logic [2:0] ra);
    wr(`IDX_DIVIDER, {18'h0, od, 1'b0, rt, 1'b0, ra});
  endtask

  // Tick spacing and level-high cycles over one period
  task automatic period(input bit which, output int p, output int h);
    p = 0;
    h = 0;
    while ((which ? ctrlBlockTick : outClockTick) !== 1'b1) begin
      @(posedge clock);
    end
    do begin
      @(posedge clock);
      p++;
      if (outClockLevel === 1'b1) h++;
    end while ((which ? ctrlBlockTick : outClockTick) !== 1'b1);
  endtask

  // ============================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk("ratioDivide reset", 32'h10, loopCfg.ratioDivide);
    chk("intMultiplier reset", 32'h177, loopCfg.intMultiplier);
    chk("gainShift reset", 32'h0, loopCfg.gainShift);
    rd(`IDX_MODE_ENABLE, 32'h0000);
    rd(`IDX_DIVIDER, 32'h0007);
    rd(`IDX_INTEGER_GAIN, 32'h2EE0);
    rd(`IDX_STATUS, 32'h0002);
    wr(`IDX_MODE_ENABLE, 32'h0002);
    wr(`IDX_MODE_ENABLE, 32'h0003);
    for (int i = 0; i < 5; i++) begin
      c = codes[i];
      if (i == 4) c = 6'($random(seed));
      if (c < 6'h03) c = 6'h03;
      wdiv(c, 3'h0, 3'h0);
      period(1'b0, per, hi);
      chk("outClock period", 32'(c) + 1, per);
      chk("outClock high", 32'(c >> 1) + 1, hi);
    end
    for (int r = 0; r < 8; r++) begin
      wdiv(6'h03, 3'(r), 3'h0);
      period(1'b1, per, hi);
      chk("ctrlBlock period", r + 1, per);
    end
    wdiv(6'h02, 3'h0, 3'h0);
    rd(`IDX_STATUS, 32'h0003);
    cnt = 0;
    repeat (40) @(posedge clock) if (outClockTick !== 1'b0) cnt++;
    chk("reserved code ticks", 32'h0, cnt);
    wdiv(6'h03, 3'h0, 3'h0);
    wr(`IDX_MODE_ENABLE, 32'h0002);
    cnt = 0;
    repeat (40) @(posedge clock) if (outClockTick !== 1'b0) cnt++;
    chk("disabled ticks", 32'h0, cnt);
    chk("loopEnable", 32'h0, loopCfg.loopEnable);
    for (int r = 0; r < 8; r++) begin
      wdiv(6'h03, 3'h0, 3'(r));
      repeat (2) @(posedge clock);
      chk("ratioDivide", r[2] ? 16 : 1 << r[1:0], loopCfg.ratioDivide);
      rd(`IDX_DIVIDER, 32'h0300 | r);
    end
    for (int g = 0; g < 16; g++) begin
      n = 10'($random(seed));
      wr(`IDX_INTEGER_GAIN, {17'h0, n, 1'b0, 4'(g)});
      loopError <= 16'($random(seed));
      repeat (4) @(posedge clock);
      ex = loopError;
      ex = ex <<< ((g > 8) ? 8 : g);
      chk("gainShift", (g > 8) ? 8 : g, loopCfg.gainShift);
      chk("scaledError", ex, scaledError);
      chk("intMultiplier", n, loopCfg.intMultiplier);
      rd(`IDX_INTEGER_GAIN, {17'h0, n, 1'b0, 4'(g)});
    end
    v = 16'($random(seed));
    wr(`IDX_FRACTION, {16'h0, v});
    wr(`IDX_MODE_ENABLE, 32'h0003);
    @(posedge clock);
    chk("fracMultiplier integer", 32'h0, loopCfg.fracMultiplier);
    chk("fractionSelect", 32'h0, loopCfg.fractionSelect);
    wr(`IDX_MODE_ENABLE, 32'hFFFF0007);
    @(posedge clock);
    chk("fracMultiplier", v, loopCfg.fracMultiplier);
    chk("oscEnable on", 32'h1, loopCfg.oscEnable);
    rd(`IDX_MODE_ENABLE, 32'h0007);
    bus(1'b1, `IDX_FRACTION, 32'hFFFF0034, 4'h1);
    rd(`IDX_FRACTION, {16'h0, v[15:8], 8'h34});
    wr(`IDX_MODE_ENABLE, 32'h0000);
    @(posedge clock);
    chk("oscEnable off", 32'h0, loopCfg.oscEnable);
    wr(8'h10, 32'h0000FFFF);
    rd(8'h10, 32'h0000);
    wr(`IDX_STATUS, 32'h0000FFFF);
    rd(`IDX_STATUS, 32'h0000);
    repeat (4) @(posedge clock);
    chk("read notes left", 32'h0, expQ.size());
    end_of_test();
  end
endmodule // testbench
